// >>> dv/nlhp_host.sv
/*
  host memory controller model for the nor-like host port: async accesses and paced bursts.
  assumes mclk at 100 MHz; every pin moves on the falling edge of mclk.
*/
`timescale 1ns/1ps
module nlhp_host (
  input  wire logic            mclk,
  input  wire logic [15:0]     devOut,
  input  wire logic            devOe,
  input  wire logic            rdyOut,
  input  wire logic            rdyOe,
  output nlhp_pkg::nlhp_pins_t pins,
  output logic      [15:0]     bus
);
  logic        hOe;
  logic [15:0] hVal;
  logic        rdyW;
  logic        lowSeen;
  logic        offSeen;
  logic [15:0] q[$];

  // ----------------------------------------
  // wires
  // ----------------------------------------
  // pins carry pull-ups, so an undriven line reads high, never the last value
  assign bus  = devOe ? devOut : (hOe ? hVal : 16'hFFFF);
  assign rdyW = rdyOe ? rdyOut : 1'b1;

  initial
  begin
    pins = 8'hFB;
    hOe  = 1'b0;
    hVal = 16'h0000;
  end

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  task automatic strap(input logic r, input logic a);
    pins.refSel  = r;
    pins.altFreq = a;
  endtask : strap

  task automatic addrPhase(input logic sync, input logic [16:0] a);
    @(negedge mclk);
    if (sync) pins.scsN = 1'b0;
    else pins.acsN = 1'b0;
    pins.advN = 1'b0;
    hOe       = 1'b1;
    hVal      = a[16:1];
    repeat (3) @(negedge mclk);
    pins.advN = 1'b1;
    @(negedge mclk);
  endtask : addrPhase

  task automatic strobe(input logic wr, input logic [15:0] wd);
    hOe  = wr;
    hVal = wd;
    if (wr) pins.weN = 1'b0;
    else pins.oeN = 1'b0;
    lowSeen = rdyOe & ~rdyOut;
  endtask : strobe

  task automatic close();
    @(negedge mclk);
    pins.oeN = 1'b1;
    pins.weN = 1'b1;
    hOe      = 1'b0;
    repeat (6) @(negedge mclk);
    pins.acsN = 1'b1;
    pins.scsN = 1'b1;
    repeat (6) @(negedge mclk);
    offSeen = ~rdyOe;
  endtask : close

  task automatic acc(input logic wr, input logic [16:0] a, input logic [15:0] wd,
                     output int lat, output logic [15:0] rd);
    addrPhase(1'b0, a);
    strobe(wr, wd);
    lat = -1;
    // strobe held until ready is seen high
    do
    begin
      @(negedge mclk);
      lat++;
    end
    while (rdyW !== 1'b1 && lat < 60);
    rd = bus;
    close();
  endtask : acc

  task automatic burst(input logic wr, input int n, output int lat, output int cnt);
    addrPhase(1'b1, 17'h10000);
    strobe(wr, 16'h0100);
    // strobe settles before the first link rise, else the port sees both in one cycle and loses that rise
    @(negedge mclk);
    lat = 0;
    cnt = 0;
    for (int k = 1; k <= 40 && cnt < n; k++)
    begin
      if (wr && rdyW === 1'b1)
      begin
        q.push_back(hVal);
        cnt++;
      end
      // 160 ns cycle, and the clock stands still outside bursts
      pins.linkClk = 1'b1;
      repeat (8) @(negedge mclk);
      if (rdyW === 1'b1 && lat == 0) lat = k;
      if (!wr && rdyW === 1'b1)
      begin
        q.push_back(bus);
        cnt++;
      end
      pins.linkClk = 1'b0;
      hVal         = hVal + 16'h0001;
      repeat (8) @(negedge mclk);
    end
    close();
  endtask : burst
endmodule : nlhp_host

// >>> dv/test_nlhp_port.sv
/*
  testbench of the nor-like host port: straps, async halves, fifo stall and paced bursts.
  assumes the host model drives the pins; register read data is driven here on the falling edge, endpoint read data on the rising edge.
*/
`timescale 1ns/1ps
module test_nlhp_port;
  typedef struct packed {
    logic        wr;
    logic [16:0] a;
    logic [15:0] d;
    logic [31:0] w;
    logic [3:0]  mn;
    logic [3:0]  mx;
  } nlhp_case_t;
  typedef struct packed {
    logic       wr;
    logic       paced;
    logic [4:0] wc;
    logic [5:0] n;
    logic [5:0] lat;
  } nlhp_burst_t;

  // reads return inverted address on top, address below; the second half must come from the store
  localparam nlhp_case_t CASES [8] = '{
    '{1'b1, 17'h00010, 16'h1357, 32'h00001357, 4'h3, 4'h5},
    '{1'b0, 17'h00012, 16'h0012, 32'h00001357, 4'h6, 4'h8},
    '{1'b1, 17'h00020, 16'hBEEF, 32'h00001357, 4'h2, 4'h4},
    '{1'b1, 17'h00022, 16'h600D, 32'h600DBEEF, 4'h3, 4'h7},
    '{1'b0, 17'h00024, 16'h0024, 32'h600DBEEF, 4'h5, 4'h7},
    '{1'b0, 17'h00026, 16'hFFDB, 32'h600DBEEF, 4'h2, 4'h4},
    '{1'b1, 17'h10000, 16'h4321, 32'h600DBEEF, 4'h3, 4'h4},
    '{1'b0, 17'h10000, 16'hA000, 32'h600DBEEF, 4'h3, 4'h4}};
  localparam nlhp_burst_t BURSTS [4] = '{
    '{1'b0, 1'b0, 5'h05, 6'h03, 6'h01},
    '{1'b0, 1'b1, 5'h00, 6'h03, 6'h01},
    '{1'b0, 1'b1, 5'h1F, 6'h02, 6'h20},
    '{1'b1, 1'b1, 5'h03, 6'h14, 6'h04}};

  logic                 mclk      = 1'b0;
  logic                 sysRst    = 1'b1;
  logic [4:0]           waitCount = 5'h00;
  logic                 dmaPaced  = 1'b0;
  logic                 regWide   = 1'b0;
  logic [31:0]          regRdData = 32'h00000000;
  logic                 epWrReady = 1'b1;
  logic [15:0]          epRdData  = 16'hA000;
  nlhp_pkg::nlhp_pins_t pins;
  logic [15:0]          bus;
  logic [15:0]          devOut;
  logic                 devOe;
  logic                 rdyOut;
  logic                 rdyOe;
  logic [16:0]          regAddr;
  logic                 regWrite;
  logic [31:0]          regWrData;
  logic [31:0]          lastWr    = 32'h00000000;
  logic [15:0]          epWrData;
  logic                 epWrValid;
  logic                 epRdReady;
  logic                 epRdValid = 1'b1;
  logic                 treq;
  logic                 regRead;
  int                   rdCount   = 0;
  logic                 useHigh;
  logic                 useLow;
  logic                 useRsv;
  int                   badCount  = 0;
  int                   checkCount = 0;

  always #5 mclk = ~mclk;

  nlhp_host host (.mclk(mclk), .devOut(devOut), .devOe(devOe), .rdyOut(rdyOut), .rdyOe(rdyOe),
                  .pins(pins), .bus(bus));

  nlhp_port dut (.mclk(mclk), .sys_rst(sysRst), .acsN(pins.acsN), .scsN(pins.scsN),
    .advN(pins.advN), .oeN(pins.oeN), .weN(pins.weN), .linkClk(pins.linkClk),
    .refClockSelectStrap(pins.refSel), .altFreqStrap(pins.altFreq), .sharedAddrDataIn(bus),
    .sharedAddrDataOut(devOut), .sharedAddrDataOe(devOe), .rdyOut(rdyOut), .rdyOe(rdyOe),
    .transferRequest(treq), .waitCount(waitCount), .dmaPaced(dmaPaced), .regWide(regWide),
    .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite), .regWrData(regWrData),
    .regRdData(regRdData), .epWrData(epWrData), .epWrValid(epWrValid), .epWrReady(epWrReady),
    .epRdData(epRdData), .epRdValid(epRdValid), .epRdReady(epRdReady),
    .useHighRefClockInput(useHigh), .useLowRefClockInput(useLow), .refClockReserved(useRsv));

  // ----------------------------------------
  // user side
  // ----------------------------------------
  always @(negedge mclk)
  begin
    regRdData <= {~regAddr[15:0], regAddr[15:0]};
    regWide   <= regAddr[5];
  end

  always @(posedge mclk)
  begin
    if (regWrite) lastWr <= regWrData;
    if (regRead) rdCount++;
    if (epRdReady) epRdData <= epRdData + 16'h0001;
    if (epWrValid && epWrReady) check("epWrData", {16'h0000, epWrData}, 32'(host.q.pop_front()));
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic reportAndStop();
    if (badCount == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : reportAndStop

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    #100000;
    badCount++;
    reportAndStop();
  end

  initial
  begin
    nlhp_case_t  c;
    nlhp_burst_t b;
    int          lat;
    int          cnt;
    logic [15:0] rd;
    logic [15:0] first;
    // straps are caught once after reset, so each pair needs its own reset
    for (int s = 0; s < 3; s++)
    begin
      // straps move after time zero, clear of the host model's own start-up values
      sysRst = 1'b1;
      @(negedge mclk);
      host.strap(s > 0, s == 1);
      repeat (3) @(negedge mclk);
      sysRst = 1'b0;
      repeat (6) @(negedge mclk);
      check("refSel", {useHigh, useLow, useRsv}, 3'b100 >> s);
    end
    foreach (CASES[i])
    begin
      c = CASES[i];
      if (c.a[16] && c.wr) host.q.push_back(c.d);
      host.acc(c.wr, c.a, c.d, lat, rd);
      check("asyncLat", 32'(lat >= c.mn && lat <= c.mx), 32'h1);
      if (!c.wr) check("rdData", {16'h0000, rd}, {16'h0000, c.d});
      check("regWrData", lastWr, c.w);
      check("asyncRdy", {host.lowSeen, host.offSeen}, 2'b11);
    end
    check("regRead", 32'(rdCount), 32'h2);
    // endpoint stream empty: the fifo read must wait for data, then take it
    first     = epRdData;
    epRdValid = 1'b0;
    fork
      host.acc(1'b0, 17'h10000, 16'h0000, lat, rd);
      begin
        repeat (20) @(negedge mclk);
        check("treqIdle", {31'h0, treq}, 32'h0);
        epRdValid = 1'b1;
      end
    join
    check("fifoStall", 32'(lat), 32'h0000000F);
    check("fifoRdData", {16'h0000, rd}, {16'h0000, first});
    foreach (BURSTS[i])
    begin
      b         = BURSTS[i];
      waitCount = b.wc;
      dmaPaced  = b.paced;
      epWrReady = !b.wr;
      first     = epRdData;
      host.burst(b.wr, b.n, lat, cnt);
      check("burstLat", 32'(lat), {26'h0, b.lat});
      check("burstRdy", {host.lowSeen, host.offSeen}, 2'b11);
      if (b.wr)
      begin
        // far side stalled: the fifo must take at least its depth and then refuse
        check("fifoFull", 32'(cnt >= 16 && cnt < 20), 32'h1);
        check("treqFull", {31'h0, treq}, 32'h0);
        epWrReady = 1'b1;
        repeat (60) @(negedge mclk);
        check("fifoDrained", 32'(host.q.size()), 32'h0);
        check("treqRoom", {31'h0, treq}, 32'h1);
      end
      else
        for (int k = 0; k < cnt; k++) check("burstData", 32'(host.q.pop_front()), 32'(first + 16'(k)));
    end
    reportAndStop();
  end
endmodule : test_nlhp_port

// >>> hw/nlhp_fifo.sv
/*
  endpoint fifo: parameter width and depth, valid/ready on both sides, registered output.
  assumes a single clock; the output stage holds one word beyond the memory depth.
*/
`timescale 1ns/1ps
module nlhp_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] inData,
  input  wire logic         inValid,
  output logic              inReady,
  output logic      [W-1:0] outData,
  output logic              outValid,
  input  wire logic         outReady
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          ov;
    logic [W-1:0]  od;
  } nlhp_fifo_st_t;

  nlhp_fifo_st_t s;
  nlhp_fifo_st_t n;
  logic [W-1:0]  mem [D];
  logic          push;
  logic          load;

  assign inReady  = (s.cnt != (AW+1)'(D));
  assign outValid = s.ov;
  assign outData  = s.od;
  assign push     = inValid && inReady;

  always_comb
  begin
    n    = s;
    load = (s.cnt != '0) && (!s.ov || outReady);
    if (outReady && s.ov)
      n.ov = 1'b0;
    if (load)
    begin
      n.od = mem[s.rp];
      n.ov = 1'b1;
      n.rp = s.rp + 1'b1;
    end
    if (push)
      n.wp = s.wp + 1'b1;
    n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[s.wp] <= inData;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= n;
  end
endmodule : nlhp_fifo

// >>> hw/nlhp_pkg.sv
/*
  types of the nor-like host port: state encoding, pin bundle, state record.
  assumes nlhp_regs.svh supplies the numeric constants.
*/
package nlhp_pkg;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    IDLE = 3'h0,
    WAIT = 3'h1,
    RDY  = 3'h3,
    BLAT = 3'h2,
    BDAT = 3'h6
  } nlhp_fsm_t;

  typedef struct packed {
    logic acsN;
    logic scsN;
    logic advN;
    logic oeN;
    logic weN;
    logic linkClk;
    logic refSel;
    logic altFreq;
  } nlhp_pins_t;

  typedef struct packed {
    nlhp_fsm_t   fsm;
    logic [5:0]  cnt;
    logic        rdy;
    logic        drv;
    logic        wr;
    logic        treq;
    logic        regRd;
    logic        regWr;
    logic [15:0] dout;
    logic [16:0] addr;
    logic [15:0] hi;
    logic [31:0] wdat;
    logic [1:0]  strapAge;
    logic        useHi;
    logic        useLo;
    logic        rsv;
    nlhp_pins_t  prv;
  } nlhp_st_t;

endpackage : nlhp_pkg

// >>> hw/nlhp_port.sv
/*
  slave side of a 16-bit multiplexed address/data nor-like host port:
  async single accesses on one chip select, bursts on another, paced by the host link clock.
  assumes host pins are asynchronous to mclk (100 MHz) and the link clock is far slower than mclk.
*/
// Contract
// - strap low at reset selects the 38.4 MHz reference input.
// - strap and frequency strap high at reset select the 19.2 MHz input.
// - async 16-bit register read: ready 6 to 8 clocks after read strobe.
// - async 32-bit read: ready 5..7 clocks first half, 2..4 second half.
// - async paced buffer read: ready 3 to 4 clocks per half.
// - async 16-bit register write: ready 3 to 5 clocks after write strobe.
// - async 32-bit write: ready 2..4 clocks first half, 3..7 second half.
// - async paced buffer write: ready 3 to 4 clocks per half.
// - async select drives ready low; deselect releases ready.
// - burst select drives ready low; deselect releases ready.
// - in bursts ready rises and read data change only on link clock edges.
// - paced burst latency follows wait count: 1 for 0 or 1, up to 32.
// - burst writes with wait count above 1 take count plus one clocks.
// - unpaced burst reads ignore the wait count.
// - shared lines carry address then data, bit numbering shifted by one.
`timescale 1ns/1ps
`include "nlhp_regs.svh"
module nlhp_port #(
  parameter int FIFO_W = 16,
  parameter int FIFO_D = 16
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        acsN,
  input  wire logic        scsN,
  input  wire logic        advN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic        linkClk,
  input  wire logic        refClockSelectStrap,
  input  wire logic        altFreqStrap,
  input  wire logic [15:0] sharedAddrDataIn,
  output logic      [15:0] sharedAddrDataOut,
  output logic             sharedAddrDataOe,
  output logic             rdyOut,
  output logic             rdyOe,
  output logic             transferRequest,
  input  wire logic [4:0]  waitCount,
  input  wire logic        dmaPaced,
  input  wire logic        regWide,
  output logic      [16:0] regAddr,
  output logic             regRead,
  output logic             regWrite,
  output logic      [31:0] regWrData,
  input  wire logic [31:0] regRdData,
  output logic      [15:0] epWrData,
  output logic             epWrValid,
  input  wire logic        epWrReady,
  input  wire logic [15:0] epRdData,
  input  wire logic        epRdValid,
  output logic             epRdReady,
  output logic             useHighRefClockInput,
  output logic             useLowRefClockInput,
  output logic             refClockReserved
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  nlhp_pkg::nlhp_pins_t pRaw;
  nlhp_pkg::nlhp_pins_t pS;
  logic [15:0]          adS;

  assign pRaw = '{acsN, scsN, advN, oeN, weN, linkClk, refClockSelectStrap, altFreqStrap};

  nlhp_sync #(
    .W   (8),
    .RST (`NLHP_PINS_IDLE)
  ) u_ctl_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .d       (pRaw),
    .q       (pS)
  );

  // data lines pass the same two stages, so they stay aligned with the strobes
  nlhp_sync #(
    .W   (16),
    .RST (16'h0000)
  ) u_ad_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .d       (sharedAddrDataIn),
    .q       (adS)
  );

  // ----------------------------------------
  // endpoint write fifo
  // ----------------------------------------
  logic push;
  logic pop;
  logic fifoInReady;

  nlhp_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_fifo (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .inData   (adS),
    .inValid  (push),
    .inReady  (fifoInReady),
    .outData  (epWrData),
    .outValid (epWrValid),
    .outReady (epWrReady)
  );

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic [5:0] accDelay(
    input logic wr,
    input logic fifo,
    input logic wide,
    input logic second
  );
    logic [5:0] c;
    c = `NLHP_RD16_CYC;
    if (fifo)
      c = `NLHP_FIFO_CYC;
    else if (wr)
      c = !wide ? `NLHP_WR16_CYC :
          (second ? `NLHP_WR32B_CYC : `NLHP_WR32A_CYC);
    else if (wide)
      c = second ? `NLHP_RD32B_CYC : `NLHP_RD32A_CYC;
    accDelay = c - `NLHP_SYNC_LAT;
  endfunction : accDelay

  function automatic logic [5:0] burstLat(
    input logic [4:0] wc,
    input logic       paced,
    input logic       wr
  );
    if (!paced && !wr)
      burstLat = `NLHP_BURST_MIN_LAT;
    else if (wc <= `NLHP_WC_SHORT)
      burstLat = `NLHP_BURST_MIN_LAT;
    else
      burstLat = {1'b0, wc} + 6'h01;
  endfunction : burstLat

  // ----------------------------------------
  // state
  // ----------------------------------------
  nlhp_pkg::nlhp_st_t s;
  nlhp_pkg::nlhp_st_t n;
  logic               acsOn;
  logic               scsOn;
  logic               oeFall;
  logic               weFall;
  logic               advRise;
  logic               clkRise;
  logic               isFifo;
  logic               second;

  assign acsOn   = !pS.acsN;
  assign scsOn   = !pS.scsN;
  assign oeFall  = s.prv.oeN && !pS.oeN;
  assign weFall  = s.prv.weN && !pS.weN;
  assign advRise = !s.prv.advN && pS.advN;
  assign clkRise = !s.prv.linkClk && pS.linkClk;
  assign isFifo  = s.addr[`NLHP_FIFO_BIT];
  assign second  = regWide && s.addr[`NLHP_HALF_BIT];

  always_comb
  begin
    n         = s;
    n.prv     = pS;
    n.regRd   = 1'b0;
    n.regWr   = 1'b0;
    push      = 1'b0;
    pop       = 1'b0;
    // straps settle through the synchroniser, then are caught once
    if (s.strapAge != 2'h3)
      n.strapAge = s.strapAge + 2'h1;
    if (s.strapAge == 2'h2)
    begin
      n.useHi = !pS.refSel;
      n.useLo = pS.refSel && pS.altFreq;
      n.rsv   = pS.refSel && !pS.altFreq;
    end
    if (advRise && (acsOn || scsOn))
      n.addr = {adS, 1'b0};
    n.treq = s.wr ? fifoInReady : epRdValid;
    case (s.fsm)
      nlhp_pkg::IDLE:
      begin
        n.rdy = 1'b0;
        n.drv = 1'b0;
        if (acsOn && (oeFall || weFall))
        begin
          n.wr    = weFall;
          n.cnt   = accDelay(weFall, isFifo, regWide, second);
          n.regRd = !weFall && !isFifo && !second;
          n.fsm   = nlhp_pkg::WAIT;
        end
        else if (scsOn && (oeFall || weFall))
        begin
          n.wr  = weFall;
          n.cnt = burstLat(waitCount, dmaPaced, weFall);
          n.fsm = nlhp_pkg::BLAT;
        end
      end
      nlhp_pkg::WAIT:
      begin
        if (!acsOn)
          n.fsm = nlhp_pkg::IDLE;
        else if (s.cnt != 6'h00)
          n.cnt = s.cnt - 6'h01;
        else if (isFifo && (s.wr ? !fifoInReady : !epRdValid))
          n.cnt = 6'h00;
        else
        begin
          n.rdy = 1'b1;
          n.fsm = nlhp_pkg::RDY;
          if (!s.wr)
          begin
            n.drv = 1'b1;
            if (isFifo)
            begin
              n.dout = epRdData;
              pop    = 1'b1;
            end
            else if (second)
              n.dout = s.hi;
            else
            begin
              n.dout = regRdData[15:0];
              n.hi   = regRdData[31:16];
            end
          end
          else if (isFifo)
            push = 1'b1;
          else if (regWide && !second)
            n.hi = adS;
          else
          begin
            n.regWr = 1'b1;
            n.wdat  = regWide ? {adS, s.hi} : {16'h0000, adS};
          end
        end
      end
      nlhp_pkg::RDY:
      begin
        // ready stands until the host lets go of its strobe
        if (!acsOn || (pS.oeN && pS.weN))
        begin
          n.rdy = 1'b0;
          n.drv = 1'b0;
          n.fsm = nlhp_pkg::IDLE;
        end
      end
      nlhp_pkg::BLAT,
      nlhp_pkg::BDAT:
      begin
        if (!scsOn)
        begin
          n.rdy = 1'b0;
          n.drv = 1'b0;
          n.fsm = nlhp_pkg::IDLE;
        end
        else
        begin
          if (pS.oeN)
            n.drv = 1'b0;
          // a full fifo drops ready at once, not waiting for the link clock
          if (s.wr && s.rdy && !fifoInReady)
            n.rdy = 1'b0;
          if (clkRise)
          begin
            if (s.fsm == nlhp_pkg::BDAT || s.cnt <= 6'h01)
            begin
              n.fsm = nlhp_pkg::BDAT;
              if (s.wr)
              begin
                push  = (s.fsm == nlhp_pkg::BDAT) && s.rdy;
                n.rdy = fifoInReady;
              end
              else if (epRdValid)
              begin
                n.dout = epRdData;
                n.drv  = 1'b1;
                n.rdy  = 1'b1;
                pop    = 1'b1;
              end
              else
                n.rdy = 1'b0;
            end
            else
              n.cnt = s.cnt - 6'h01;
          end
        end
      end
      default:
      begin
        n.fsm = nlhp_pkg::IDLE;
        n.rdy = 1'b0;
        n.drv = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s     <= '0;
      s.prv <= `NLHP_PINS_IDLE;
    end
    else
      s <= n;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign sharedAddrDataOut    = s.dout;
  assign sharedAddrDataOe     = s.drv;
  assign rdyOut               = s.rdy;
  assign rdyOe                = acsOn || scsOn;
  assign transferRequest      = s.treq;
  assign regAddr              = s.addr;
  assign regRead              = s.regRd;
  assign regWrite             = s.regWr;
  assign regWrData            = s.wdat;
  assign epRdReady            = pop;
  assign useHighRefClockInput = s.useHi;
  assign useLowRefClockInput  = s.useLo;
  assign refClockReserved     = s.rsv;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_rd_start;
    s.fsm == nlhp_pkg::IDLE && acsOn && oeFall && !isFifo;
  endsequence

  sequence s_wr_start;
    s.fsm == nlhp_pkg::IDLE && acsOn && weFall && !isFifo;
  endsequence

  property p_ref_high;
    (s.strapAge == 2'h2 && !pS.refSel) |=> (useHighRefClockInput && !useLowRefClockInput);
  endproperty
  a_ref_high: assert property (p_ref_high) else $error("high reference not chosen");

  property p_ref_low;
    (s.strapAge == 2'h2 && pS.refSel && pS.altFreq) |=> (useLowRefClockInput && !useHighRefClockInput);
  endproperty
  a_ref_low: assert property (p_ref_low) else $error("low reference not chosen");

  property p_rd16;
    (s_rd_start and (!regWide)) |-> ##4 !s.rdy ##1 (s.rdy || !acsOn);
  endproperty
  a_rd16: assert property (p_rd16) else $error("16-bit read ready out of window");

  property p_rd32b;
    (s_rd_start and (second)) |-> ##1 !s.rdy ##1 (s.rdy || !acsOn);
  endproperty
  a_rd32b: assert property (p_rd32b) else $error("second read half ready late");

  property p_wr16;
    (s_wr_start and (!regWide)) |-> ##1 !s.rdy ##1 (s.rdy || !acsOn);
  endproperty
  a_wr16: assert property (p_wr16) else $error("16-bit write ready out of window");

  property p_sel_low;
    ((acsOn || scsOn) && s.fsm == nlhp_pkg::IDLE) |-> (rdyOe && !rdyOut);
  endproperty
  a_sel_low: assert property (p_sel_low) else $error("ready not driven low on select");

  property p_burst_rise;
    ($rose(s.rdy) && s.fsm == nlhp_pkg::BDAT) |-> $past(clkRise);
  endproperty
  a_burst_rise: assert property (p_burst_rise) else $error("burst ready rose off link edge");

  property p_lat_max;
    (s.fsm == nlhp_pkg::IDLE && scsOn && oeFall && dmaPaced && waitCount == 5'h1F) |=> (s.cnt == 6'h20);
  endproperty
  a_lat_max: assert property (p_lat_max) else $error("burst latency not 32");

  property p_unpaced;
    (s.fsm == nlhp_pkg::IDLE && scsOn && oeFall && !weFall && !dmaPaced) |=> (s.cnt == 6'h01);
  endproperty
  a_unpaced: assert property (p_unpaced) else $error("unpaced read used wait count");

  property p_addr;
    (advRise && acsOn) |=> (s.addr == {$past(adS), 1'b0});
  endproperty
  a_addr: assert property (p_addr) else $error("address not latched");

endmodule : nlhp_port

// >>> hw/nlhp_regs.svh
/*
  constants of the nor-like host port: access latencies, address layout, burst latency, pin reset values.
  assumes the system clock mclk runs at 100 MHz; included by the port alone, not by its package users.
*/
`ifndef NLHP_REGS_SVH
`define NLHP_REGS_SVH

// ----------------------------------------
// clock figures
// ----------------------------------------
`define NLHP_MCLK_MHZ        100
`define NLHP_LINK_MAX_KHZ    67500

// ----------------------------------------
// async access, total system clocks from strobe fall to ready
// ----------------------------------------
`define NLHP_SYNC_LAT        6'h04
`define NLHP_RD16_CYC        6'h07
`define NLHP_RD32A_CYC       6'h06
`define NLHP_RD32B_CYC       6'h04
`define NLHP_WR16_CYC        6'h04
`define NLHP_WR32A_CYC       6'h04
`define NLHP_WR32B_CYC       6'h05
`define NLHP_FIFO_CYC        6'h04

// ----------------------------------------
// address layout, reset values and burst latency limits
// ----------------------------------------
`define NLHP_FIFO_BIT        16
`define NLHP_HALF_BIT        1
`define NLHP_PINS_IDLE       8'hFF
`define NLHP_BURST_MIN_LAT   6'h01
`define NLHP_WC_SHORT        5'h01

`endif

// >>> hw/nlhp_sync.sv
/*
  two-flop synchroniser for a vector of unrelated levels.
  assumes each bit is a slow level; no bus coherence is promised across bits.
*/
`timescale 1ns/1ps
module nlhp_sync #(
  parameter int         W   = 8,
  parameter logic [W-1:0] RST = '1
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      meta <= RST;
      q    <= RST;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : nlhp_sync
